// ---- design/slc_pkg.sv ----
// shared constants and types for the segmented instruction cache
// assumes a single 125 MHz clock domain and 16-bit instruction words
package slc_pkg;
    localparam int SLC_PTR_W = 32;
    localparam int SLC_WORD_W = 16;
    localparam int SLC_CAP_BYTES = 256;
    localparam int SLC_SEG_BYTES = 64;
    localparam int SLC_SEG_N = 4;
    localparam int SLC_SUB_N = 8;
    localparam int SLC_SUB_WORDS = 4;
    localparam int SLC_TAG_W = 23;
    // bit positions inside the bit-granular fetch pointer
    localparam int SLC_WORD_LSB = 4;
    localparam int SLC_SUB_LSB = 6;
    localparam int SLC_TAG_LSB = 9;
    localparam logic [3:0] SLC_PTR_ZERO = 4'h0;
    localparam logic [5:0] SLC_SUB_ZERO = 6'h00;
    localparam logic [31:0] SLC_VALID_RST = 32'h0000_0000;
    localparam logic [3:0] SLC_USED_RST = 4'h0;
    localparam logic [1:0] SLC_LAST_BEAT = 2'h3;

    typedef enum logic [1:0] {
        SLC_IDLE = 2'b00,
        SLC_LOOK = 2'b01,
        SLC_FILL = 2'b10
    } slc_state_t;
endpackage

// ---- design/slc_lru.sv ----
// usage-order stack: segment indices from most to least recently used
// assumes touch is a one-cycle pulse synchronous to clk
`timescale 1ns/1ps
module slc_lru import slc_pkg::*; #(
    parameter int NSEG = SLC_SEG_N
) (
    input wire logic clk, // system clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic touch, // access pulse
    input wire logic [$clog2(NSEG)-1:0] touch_idx, // segment accessed
    output logic [$clog2(NSEG)-1:0] victim // least recently used segment
);
    localparam int IW = $clog2(NSEG);

    if (NSEG < 2 || (1 << IW) != NSEG) begin : g_chk
        $error("slc_lru: NSEG must be a power of two, at least 2");
    end

    logic [IW-1:0] stack_r [NSEG];

    logic [NSEG-1:0] present;

    // true when idx sits above position pos: entries from pos down keep their place
    function automatic logic found_above(input int pos, input logic [IW-1:0] idx);
        logic f;
        f = 1'b0;
        for (int j = 0; j < pos; j++) begin
            if (stack_r[j] == idx) begin
                f = 1'b1;
            end
        end
        return f;
    endfunction

    // every index must appear once, or a segment could never be chosen as victim
    always_comb begin
        present = '0;
        for (int i = 0; i < NSEG; i++) begin
            present[stack_r[i]] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < NSEG; i++) begin
                stack_r[i] <= IW'(i);
            end
        end else if (touch) begin
            stack_r[0] <= touch_idx;
            for (int i = 1; i < NSEG; i++) begin
                stack_r[i] <= found_above(i, touch_idx) ? stack_r[i] : stack_r[i-1];
            end
        end
    end

    assign victim = stack_r[NSEG-1];

    a_lru_top: assert property (@(posedge clk) disable iff (!rst_b)
        touch |=> stack_r[0] == $past(touch_idx))
        else $error("touched segment not at top of usage stack");
    a_lru_perm: assert property (@(posedge clk) disable iff (!rst_b)
        present == '1)
        else $error("usage stack holds a duplicate index");
endmodule // slc_lru

// ---- design/slc_cache.sv ----
// four-segment instruction cache with per-subsegment valid flags
// assumes fetch and fill sides are synchronous logic on SYS_CLK
`timescale 1ns/1ps
module slc_cache import slc_pkg::*; (
    input wire logic SYS_CLK, // 125 MHz clock
    input wire logic RST_B, // synchronous reset, active low
    input wire logic FETCH_REQ, // fetch request, held until ack
    input wire logic [SLC_PTR_W-1:0] FETCH_PTR, // instruction_fetch_pointer, bit address
    output logic FETCH_ACK, // fetch done pulse
    output logic [SLC_WORD_W-1:0] FETCH_DATA, // fetched instruction word
    input wire logic FLUSH, // invalidate pulse from host control
    output logic FILL_REQ, // fill request, held until four beats
    output logic [SLC_PTR_W-1:0] FILL_ADDR, // bit address of subsegment start
    input wire logic FILL_VALID, // fill data beat
    input wire logic [SLC_WORD_W-1:0] FILL_DATA // fill word, lowest address first
);
    localparam int SEG_IW = $clog2(SLC_SEG_N);
    localparam int SUB_IW = $clog2(SLC_SUB_N);
    localparam int WRD_IW = $clog2(SLC_SUB_WORDS);
    localparam int MEM_N = SLC_SEG_N * SLC_SUB_N * SLC_SUB_WORDS;

    if (MEM_N * 2 != SLC_CAP_BYTES || SLC_SUB_N * SLC_SUB_WORDS * 2 != SLC_SEG_BYTES
        || SLC_TAG_LSB + SLC_TAG_W != SLC_PTR_W) begin : g_chk
        $error("slc_cache: geometry constants are inconsistent");
    end

    ////////////////////////////////////////////////////////////////////////
    // storage and lookup

    slc_state_t state_r;
    logic [SLC_PTR_W-1:0] ptr_r;
    logic [SLC_TAG_W-1:0] tag_r [SLC_SEG_N];
    logic [SLC_SEG_N-1:0] used_r;
    logic [SLC_SEG_N*SLC_SUB_N-1:0] valid_r;
    logic [SLC_WORD_W-1:0] mem [MEM_N];
    logic [WRD_IW-1:0] cnt_r;
    logic [SEG_IW-1:0] fill_seg_r;
    logic flush_seen_r;
    logic [SEG_IW-1:0] victim;
    logic [SEG_IW-1:0] hit_seg;
    logic tag_hit;
    logic hit;
    logic fill_done;

    wire [SLC_TAG_W-1:0] look_tag = ptr_r[SLC_TAG_LSB +: SLC_TAG_W];
    wire [SUB_IW-1:0] look_sub = ptr_r[SLC_SUB_LSB +: SUB_IW];
    wire [WRD_IW-1:0] look_wrd = ptr_r[SLC_WORD_LSB +: WRD_IW];

    function automatic logic [SEG_IW+SUB_IW+WRD_IW-1:0] mem_idx(
        input logic [SEG_IW-1:0] s, input logic [SUB_IW-1:0] u, input logic [WRD_IW-1:0] w);
        return {s, u, w};
    endfunction

    always_comb begin
        tag_hit = 1'b0;
        hit_seg = '0;
        for (int i = SLC_SEG_N - 1; i >= 0; i--) begin
            if (used_r[i] && tag_r[i] == look_tag) begin
                tag_hit = 1'b1;
                hit_seg = SEG_IW'(i);
            end
        end
    end

    assign hit = tag_hit && valid_r[{hit_seg, look_sub}];
    assign fill_done = state_r == SLC_FILL && FILL_VALID && cnt_r == SLC_LAST_BEAT;

    slc_lru #(
        .NSEG(SLC_SEG_N)
    ) u_lru (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .touch(state_r == SLC_LOOK && !FLUSH && hit),
        .touch_idx(hit_seg),
        .victim(victim)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencing: lookup, allocate, fill, retry

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            state_r <= SLC_IDLE;
            ptr_r <= '0;
        end else begin
            case (state_r)
                SLC_IDLE: begin
                    if (FETCH_REQ) begin
                        ptr_r <= FETCH_PTR;
                        state_r <= SLC_LOOK;
                    end
                end
                SLC_LOOK: begin
                    // a flush in this cycle holds the lookup one cycle, then retries
                    if (FLUSH) begin
                        state_r <= SLC_LOOK;
                    end else if (hit) begin
                        state_r <= SLC_IDLE;
                    end else begin
                        state_r <= SLC_FILL;
                    end
                end
                SLC_FILL: begin
                    if (fill_done) begin
                        state_r <= SLC_LOOK;
                    end
                end
                default: begin
                    state_r <= SLC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            used_r <= SLC_USED_RST;
            fill_seg_r <= '0;
            for (int i = 0; i < SLC_SEG_N; i++) begin
                tag_r[i] <= '0;
            end
        end else if (FLUSH) begin
            used_r <= SLC_USED_RST;
        end else if (state_r == SLC_LOOK && !hit) begin
            if (tag_hit) begin
                fill_seg_r <= hit_seg;
            end else begin
                fill_seg_r <= victim;
                tag_r[victim] <= look_tag;
                used_r[victim] <= 1'b1;
            end
        end
    end

    // flush beats a fill completing in the same cycle: stale data must not survive
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B || FLUSH) begin
            valid_r <= SLC_VALID_RST;
        end else if (state_r == SLC_LOOK && !tag_hit) begin
            valid_r[victim*SLC_SUB_N +: SLC_SUB_N] <= '0;
        end else if (fill_done && !flush_seen_r) begin
            valid_r[{fill_seg_r, look_sub}] <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            cnt_r <= '0;
            flush_seen_r <= 1'b0;
        end else if (state_r == SLC_LOOK) begin
            cnt_r <= '0;
            flush_seen_r <= 1'b0;
        end else if (state_r == SLC_FILL) begin
            if (FILL_VALID) begin
                cnt_r <= cnt_r + 1'b1;
            end
            if (FLUSH) begin
                flush_seen_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (state_r == SLC_FILL && FILL_VALID) begin
            mem[mem_idx(fill_seg_r, look_sub, cnt_r)] <= FILL_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            FETCH_ACK <= 1'b0;
            FETCH_DATA <= '0;
        end else begin
            FETCH_ACK <= state_r == SLC_LOOK && !FLUSH && hit;
            if (state_r == SLC_LOOK && !FLUSH && hit) begin
                FETCH_DATA <= mem[mem_idx(hit_seg, look_sub, look_wrd)];
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            FILL_REQ <= 1'b0;
            FILL_ADDR <= '0;
        end else if (state_r == SLC_LOOK && !FLUSH && !hit) begin
            FILL_REQ <= 1'b1;
            FILL_ADDR <= {ptr_r[SLC_PTR_W-1:SLC_SUB_LSB], SLC_SUB_ZERO};
        end else if (fill_done) begin
            FILL_REQ <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_fill_on_miss: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        $rose(FILL_REQ) |-> $past(state_r == SLC_LOOK && !hit))
        else $error("fill requested without a miss");
    a_ack_on_hit: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        FETCH_ACK |-> $past(state_r == SLC_LOOK && tag_hit && valid_r[{hit_seg, look_sub}]))
        else $error("ack given without a valid subsegment");
    a_ack_data: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        FETCH_ACK |-> FETCH_DATA == $past(mem[mem_idx(hit_seg, look_sub, look_wrd)]))
        else $error("fetched word differs from stored word");
    a_alloc_tag: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (state_r == SLC_LOOK && !FLUSH && !tag_hit)
        |=> tag_r[$past(victim)] == $past(look_tag) && fill_seg_r == $past(victim))
        else $error("allocation did not load the victim tag");
    a_alloc_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (state_r == SLC_LOOK && !tag_hit)
        |=> valid_r[$past(victim)*SLC_SUB_N +: SLC_SUB_N] == '0)
        else $error("allocation left valid flags set");
    a_flush_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        FLUSH |=> valid_r == SLC_VALID_RST && used_r == SLC_USED_RST)
        else $error("flush left cache contents valid");
    a_fill_sets: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (fill_done && !flush_seen_r && !FLUSH)
        |=> valid_r[{fill_seg_r, look_sub}] ##1 (FETCH_ACK || $past(FLUSH)))
        else $error("completed fill did not validate its subsegment");
    a_flush_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (state_r == SLC_LOOK && FLUSH) |=> state_r == SLC_LOOK && !FETCH_ACK && !FILL_REQ)
        else $error("lookup not held for a flush");
    a_fill_addr: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        FILL_REQ |-> FILL_ADDR[SLC_SUB_LSB-1:0] == SLC_SUB_ZERO
        && FILL_ADDR[SLC_PTR_W-1:SLC_TAG_LSB] == look_tag)
        else $error("fill address not aligned to the subsegment");
endmodule // slc_cache

// ---- tb/slc_mem_model.sv ----
// fill-side memory model for the segmented instruction cache
// assumes fill beats are taken on rising SYS_CLK edges while fill_req is high
`timescale 1ns/1ps
module slc_mem_model (
    input wire logic clk, // system clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic fill_req, // fill request from the cache
    input wire logic [31:0] fill_addr, // subsegment start, bit address
    input wire logic [15:0] salt, // memory content pattern
    input wire logic slow, // spaces beats two cycles apart
    output logic fill_valid, // beat strobe
    output logic [15:0] fill_data, // beat word
    output int fills // completed fills
);
    int n;
    logic gap;
    initial begin
        fill_valid = 1'b0;
        fill_data = 16'h0000;
        fills = 0;
        n = 0;
        gap = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // word content is word address xor salt, so stale cached data shows after a salt change
    always @(posedge clk) begin
        if (fill_req && fill_valid) n = n + 1;
        if (fill_req && fill_valid && n == 4) fills = fills + 1;
        if (!fill_req || !rst_b) n = 0;
        gap = slow ? !gap : 1'b1;
        if (fill_req && rst_b && n < 4 && gap) begin
            fill_valid <= 1'b1;
            fill_data <= (fill_addr[19:4] + n[15:0]) ^ salt;
        end else begin
            fill_valid <= 1'b0;
            // released bus must not keep showing the last word
            fill_data <= ~fill_data;
        end
    end
endmodule // slc_mem_model

// ---- tb/slc_cache_tb_top.sv ----
// self-checking testbench for the segmented instruction cache
// assumes the design files and package are compiled first
`timescale 1ns/1ps
module slc_cache_tb_top import slc_pkg::*; ;
    logic sys_clk, rst_b, fetch_req, flush, fetch_ack, fill_req, fill_valid, slow;
    logic [31:0] fetch_ptr, fill_addr;
    logic [15:0] fetch_data, fill_data, salt;
    int fills, num_errors, checked;

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    slc_cache dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .FETCH_REQ(fetch_req),
        .FETCH_PTR(fetch_ptr), .FETCH_ACK(fetch_ack), .FETCH_DATA(fetch_data), .FLUSH(flush),
        .FILL_REQ(fill_req), .FILL_ADDR(fill_addr), .FILL_VALID(fill_valid),
        .FILL_DATA(fill_data));
    slc_mem_model mem (.clk(sys_clk), .rst_b(rst_b), .fill_req(fill_req),
        .fill_addr(fill_addr), .salt(salt), .slow(slow), .fill_valid(fill_valid),
        .fill_data(fill_data), .fills(fills));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // one fetch from a falling edge; pointers keep their low four bits zero
    task automatic fetch(input logic [31:0] p, input logic [15:0] xs, input int dfill,
            input int lat);
        int n;
        int f0;
        n = 0;
        f0 = fills;
        fetch_req = 1'b1;
        fetch_ptr = p;
        do begin
            @(negedge sys_clk);
            n++;
        end while (fetch_ack !== 1'b1 && n < 100);
        fetch_req = 1'b0;
        if (fetch_ack !== 1'b1) begin
            num_errors++;
            end_of_test();
        end else begin
            chk(fetch_data, p[19:4] ^ xs);
            chk(fills - f0, dfill);
            if (lat > 0) chk(n <= lat, 1);
            @(negedge sys_clk);
        end
    endtask

    task automatic pulse_flush();
        flush = 1'b1;
        @(negedge sys_clk);
        flush = 1'b0;
        @(negedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(fetch_ack, 0);
        chk(fill_req, 0);
        chk(fetch_data, 0);
        chk(fill_addr, 0);
    endtask

    // words of one subsegment, then other subsegments of the same segment
    task automatic t_subseg();
        salt = 16'h5A5A;
        fetch(32'h0000_0430, salt, 1, 0);
        for (int w = 0; w < 4; w++) begin
            fetch(32'h0000_0400 | (w << 4), salt, 0, 3);
        end
        fetch(32'h0000_0440, salt, 1, 0);
        fetch(32'h0000_05F0, salt, 1, 0);
        fetch(32'h0000_0410, salt, 0, 3);
    endtask

    // four tags resident, one touched, fifth tag evicts the least recently used
    task automatic t_lru();
        pulse_flush();
        salt = 16'h1234;
        for (int k = 0; k < 4; k++) begin
            fetch(32'h0000_1000 + k * 32'h0000_0200, salt, 1, 0);
        end
        fetch(32'h0000_1000, 16'h1234, 0, 3);
        salt = 16'hBEEF;
        fetch(32'h0000_1800, salt, 1, 0);
        fetch(32'h0000_1000, 16'h1234, 0, 3);
        fetch(32'h0000_1400, 16'h1234, 0, 3);
        fetch(32'h0000_1600, 16'h1234, 0, 3);
        fetch(32'h0000_1200, salt, 1, 0);
    endtask

    // flush forces reload; a flush inside a slow fill makes that fill repeat
    task automatic t_flush();
        salt = 16'h0F0F;
        pulse_flush();
        fetch(32'h0000_1000, salt, 1, 0);
        slow = 1'b1;
        fork
            fetch(32'h0000_1080, salt, 2, 0);
            begin
                repeat (4) @(negedge sys_clk);
                pulse_flush();
            end
        join
        slow = 1'b0;
        fetch(32'h0000_1000, salt, 1, 0);
        fetch(32'h0000_1000, salt, 0, 3);
        // flush lands on the lookup cycle of a hit: lookup holds, then misses and refills
        fork
            fetch(32'h0000_1000, salt, 1, 0);
            begin
                @(negedge sys_clk);
                pulse_flush();
            end
        join
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0;
        checked = 0;
        rst_b = 1'b0;
        fetch_req = 1'b0;
        fetch_ptr = 32'h0000_0000;
        flush = 1'b0;
        slow = 1'b0;
        salt = 16'h0000;
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
        t_reset();
        t_subseg();
        t_lru();
        t_flush();
        end_of_test();
    end
endmodule // slc_cache_tb_top
